// ---- core/dar_pkg.sv ----
package dar_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [4:0]  DAR_ADDR_DIE_TEMP    = 5'h06;
  localparam logic [4:0]  DAR_ADDR_ALARM_SUPP  = 5'h07;
  localparam logic [4:0]  DAR_ADDR_I_OFFSET    = 5'h08;
  localparam logic [4:0]  DAR_ADDR_RDPTR_Q_OFF = 5'h09;
  localparam logic [4:0]  DAR_ADDR_RSVD_A      = 5'h0a;
  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [15:0] DAR_RST_ALARM_SUPP   = 16'hffff;
  localparam logic [15:0] DAR_RST_I_OFFSET     = 16'h0000;
  localparam logic [15:0] DAR_RST_RDPTR_Q_OFF  = 16'h8000;
  localparam logic [15:0] DAR_RST_RSVD_A       = 16'h0000;
  localparam logic [15:0] DAR_FORCED_OUT_WORD  = 16'h8000;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int DAR_TEMP_MSB       = 15;
  localparam int DAR_TEMP_LSB       = 8;
  localparam int DAR_OFS_MSB        = 12;
  localparam int DAR_RDPTR_MSB      = 15;
  localparam int DAR_RDPTR_LSB      = 13;
  localparam logic [15:0] DAR_ALARM_USED_MASK = 16'hbfbc;
  localparam int DAR_ALM_ZERO_WP    = 15;
  localparam int DAR_ALM_COLLISION  = 13;
  localparam int DAR_ALM_ONE_APART  = 12;
  localparam int DAR_ALM_TWO_APART  = 11;
  localparam int DAR_ALM_OUT_FORCED = 8;
  // ****************************************************
  // timing: least serial clock period on temperature reads
  // ****************************************************
  localparam int DAR_TEMP_SCLK_NS     = 1000;
  localparam int DAR_CLK_NS           = 10;
  localparam int DAR_TEMP_SCLK_CYCLES = (DAR_TEMP_SCLK_NS + DAR_CLK_NS - 1) / DAR_CLK_NS;
  // ****************************************************
  // pointer distance encodings
  // ****************************************************
  typedef enum logic [1:0] {
    DAR_PTR_FINE      = 2'b00,
    DAR_PTR_TWO_APART = 2'b01,
    DAR_PTR_ONE_APART = 2'b10,
    DAR_PTR_COLLIDE   = 2'b11
  } dar_ptr_dist_t;
endpackage

// ---- core/dar_ptr_decode.sv ----
`timescale 1ns/1ps
// ****************************************************
// pointer distance field decoder
// ****************************************************
module dar_ptr_decode (
  input  wire logic [2:0]             dist_field_i,
  output dar_pkg::dar_ptr_dist_t      dist_o,
  output logic                        one_apart_o,
  output logic                        two_apart_o,
  output logic                        collision_o
);
  import dar_pkg::*;

  // priority decode, collision dominates lesser distances
  always_comb begin
    if (dist_field_i[2]) begin
      dist_o = DAR_PTR_COLLIDE;
    end else if (dist_field_i[1]) begin
      dist_o = DAR_PTR_ONE_APART;
    end else if (dist_field_i[0]) begin
      dist_o = DAR_PTR_TWO_APART;
    end else begin
      dist_o = DAR_PTR_FINE;
    end
  end

  assign collision_o = (dist_o == DAR_PTR_COLLIDE);
  assign one_apart_o = (dist_o == DAR_PTR_ONE_APART);
  assign two_apart_o = (dist_o == DAR_PTR_TWO_APART);
endmodule

// ---- core/dar_regs.sv ----
`timescale 1ns/1ps
module dar_regs (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic [7:0]  temp_sensor_i,
  input  wire logic        auto_sync_en_i,
  input  wire logic        fifo_sync_i,
  input  wire logic [15:0] alarm_status_i,
  input  wire logic [15:0] conv_i_data_i,
  input  wire logic [15:0] conv_q_data_i,
  output logic      [12:0] i_path_dc_correction_o,
  output logic      [12:0] q_path_dc_correction_o,
  output logic             offset_load_o,
  output logic      [2:0]  fifo_rdptr_load_o,
  output logic             fifo_rdptr_load_en_o,
  output logic             alarm_o,
  output logic      [15:0] alarm_active_o,
  output logic             ptr_one_apart_flag_o,
  output logic             ptr_two_apart_flag_o,
  output logic      [15:0] conv_i_out_o,
  output logic      [15:0] conv_q_out_o
);
  import dar_pkg::*;

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    return a == r;
  endfunction

  logic [15:0] alarm_supp_q;
  logic [12:0] i_ofs_q;
  logic [15:0] rdptr_q_q;
  logic [12:0] i_live_q;
  logic [12:0] q_live_q;
  logic        load_q;
  logic        auto_sync;
  logic [2:0]  rdptr_q;
  logic        rdptr_en_q;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic        rvalid_q;
  logic        alarm_q;
  logic [15:0] act_q;
  logic        one_ap;
  logic        two_ap;
  logic        coll;
  logic [15:0] i_out_q;
  logic [15:0] q_out_q;

  // ****************************************************
  // writable registers
  // ****************************************************
  // alarm suppress register
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      alarm_supp_q <= DAR_RST_ALARM_SUPP;
    end else if (reg_wr_i && hit(reg_addr_i, DAR_ADDR_ALARM_SUPP)) begin
      alarm_supp_q <= reg_wdata_i & DAR_ALARM_USED_MASK;
    end
  end

  // i offset register; reserved top bits are not stored
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      i_ofs_q <= DAR_RST_I_OFFSET[DAR_OFS_MSB:0];
    end else if (reg_wr_i && hit(reg_addr_i, DAR_ADDR_I_OFFSET)) begin
      i_ofs_q <= reg_wdata_i[DAR_OFS_MSB:0];
    end
  end

  // read pointer init and q offset share one word
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rdptr_q_q <= DAR_RST_RDPTR_Q_OFF;
    end else if (reg_wr_i && hit(reg_addr_i, DAR_ADDR_RDPTR_Q_OFF)) begin
      rdptr_q_q <= {reg_wdata_i[DAR_RDPTR_MSB:DAR_RDPTR_LSB], reg_wdata_i[DAR_OFS_MSB:0]};
    end
  end

  // ****************************************************
  // offset transfer into the datapath
  // ****************************************************
  // same-cycle write data is used so a single i write carries its new value
  assign auto_sync = reg_wr_i && hit(reg_addr_i, DAR_ADDR_I_OFFSET) && auto_sync_en_i;

  // live copies change only on auto-sync, never on a lone q write
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      i_live_q <= DAR_RST_I_OFFSET[DAR_OFS_MSB:0];
      q_live_q <= DAR_RST_RDPTR_Q_OFF[DAR_OFS_MSB:0];
      load_q   <= 1'b0;
    end else begin
      load_q <= auto_sync;
      if (auto_sync) begin
        i_live_q <= reg_wdata_i[DAR_OFS_MSB:0];
        q_live_q <= rdptr_q_q[DAR_OFS_MSB:0];
      end
    end
  end

  assign i_path_dc_correction_o = i_live_q;
  assign q_path_dc_correction_o = q_live_q;
  assign offset_load_o          = load_q;

  // ****************************************************
  // fifo read pointer load
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rdptr_q    <= DAR_RST_RDPTR_Q_OFF[DAR_RDPTR_MSB:DAR_RDPTR_LSB];
      rdptr_en_q <= 1'b0;
    end else begin
      rdptr_en_q <= fifo_sync_i;
      if (fifo_sync_i) begin
        rdptr_q <= rdptr_q_q[DAR_RDPTR_MSB:DAR_RDPTR_LSB];
      end
    end
  end

  assign fifo_rdptr_load_o    = rdptr_q;
  assign fifo_rdptr_load_en_o = rdptr_en_q;

  // ****************************************************
  // read path
  // ****************************************************
  // temperature is sampled at read time, so it has no reset value of its own
  always_comb begin
    case (reg_addr_i)
      DAR_ADDR_DIE_TEMP:    rdata_d = {temp_sensor_i, 8'h00};
      DAR_ADDR_ALARM_SUPP:  rdata_d = alarm_supp_q;
      DAR_ADDR_I_OFFSET:    rdata_d = {3'h0, i_ofs_q};
      DAR_ADDR_RDPTR_Q_OFF: rdata_d = rdptr_q_q;
      DAR_ADDR_RSVD_A:      rdata_d = DAR_RST_RSVD_A;
      default:              rdata_d = 16'h0000;
    endcase
  end

  // one cycle read latency; slow temperature reads are the host's concern
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // ****************************************************
  // alarm gating
  // ****************************************************
  dar_ptr_decode u_ptr_decode (
    .dist_field_i (alarm_status_i[DAR_ALM_COLLISION:DAR_ALM_TWO_APART]),
    .dist_o       (),
    .one_apart_o  (one_ap),
    .two_apart_o  (two_ap),
    .collision_o  (coll)
  );

  // status stays untouched here; mask gates both alarm_active_o and the summary output
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      act_q   <= 16'h0000;
      alarm_q <= 1'b0;
    end else begin
      act_q   <= alarm_status_i & ~alarm_supp_q & DAR_ALARM_USED_MASK;
      alarm_q <= |(alarm_status_i & ~alarm_supp_q & DAR_ALARM_USED_MASK);
    end
  end

  assign alarm_o              = alarm_q;
  assign alarm_active_o       = act_q;
  assign ptr_one_apart_flag_o = one_ap;
  assign ptr_two_apart_flag_o = two_ap;

  // ****************************************************
  // forced converter output
  // ****************************************************
  // collision decode also forces, covering a status word not yet summarised
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      i_out_q <= DAR_FORCED_OUT_WORD;
      q_out_q <= DAR_FORCED_OUT_WORD;
    end else if (alarm_status_i[DAR_ALM_OUT_FORCED] || coll) begin
      i_out_q <= DAR_FORCED_OUT_WORD;
      q_out_q <= DAR_FORCED_OUT_WORD;
    end else begin
      i_out_q <= conv_i_data_i;
      q_out_q <= conv_q_data_i;
    end
  end

  assign conv_i_out_o = i_out_q;
  assign conv_q_out_o = q_out_q;
endmodule

// ---- bench/dar_regs_chk.sv ----
`timescale 1ns/1ps
// ****************************************************
// port checker for the register slice
// ****************************************************
module dar_regs_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [4:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [7:0]  temp_sensor_i,
  input wire logic        auto_sync_en_i,
  input wire logic        fifo_sync_i,
  input wire logic [15:0] alarm_status_i,
  input wire logic [12:0] i_path_dc_correction_o,
  input wire logic [12:0] q_path_dc_correction_o,
  input wire logic        offset_load_o,
  input wire logic        fifo_rdptr_load_en_o,
  input wire logic [15:0] alarm_active_o,
  input wire logic        ptr_two_apart_flag_o,
  input wire logic [15:0] conv_i_out_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // low byte of the temperature word is reserved and reads zero
  temp_rd_a: assert property (reg_rd_i && reg_addr_i == 5'h06 |=>
    reg_rdata_o == {$past(temp_sensor_i), 8'h00}) else $error("temperature read wrong");
  rsvd_rd_a: assert property (reg_rd_i && reg_addr_i == 5'h0a |=>
    reg_rdata_o == 16'h0000) else $error("reserved register not zero");
  auto_load_a: assert property (reg_wr_i && reg_addr_i == 5'h08 && auto_sync_en_i |=>
    offset_load_o && {3'h0, i_path_dc_correction_o} == ($past(reg_wdata_i) & 16'h1fff))
    else $error("auto-sync load missing");
  // past reset guard: a one-edge reset would otherwise look like a change
  q_hold_a: assert property (rst_b_i && $past(rst_b_i) && !offset_load_o |->
    $stable(q_path_dc_correction_o) && $stable(i_path_dc_correction_o))
    else $error("offset moved without a load");
  ptr_load_a: assert property (fifo_sync_i |=> fifo_rdptr_load_en_o)
    else $error("read pointer not loaded");
  alarm_gate_a: assert property ((alarm_active_o & ~($past(alarm_status_i) & 16'hbfbc)) == 0)
    else $error("alarm active without status");
  forced_out_a: assert property ($past(alarm_status_i[8]) |-> conv_i_out_o == 16'h8000)
    else $error("output not forced");
  two_apart_a: assert property (alarm_status_i[13:11] == 3'b001 |-> ptr_two_apart_flag_o)
    else $error("two-apart flag missing");
  cover property (offset_load_o);
  cover property (fifo_rdptr_load_en_o);
  cover property (alarm_active_o != 16'h0000);
endmodule
bind dar_regs dar_regs_chk u_chk (.*);

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, auto_sync_en_i, fifo_sync_i;
  logic [4:0]  reg_addr_i;
  logic [7:0]  temp_sensor_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, alarm_status_i, alarm_active_o;
  logic [15:0] conv_i_data_i, conv_q_data_i, conv_i_out_o, conv_q_out_o;
  logic [12:0] i_cor, q_cor;
  logic [2:0]  rdptr;
  logic        reg_rvalid_o, offset_load_o, rdptr_en, alarm_o, one_ap, two_ap;
  int          failures, n_tests;
  dar_regs u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .temp_sensor_i(temp_sensor_i),
    .auto_sync_en_i(auto_sync_en_i), .fifo_sync_i(fifo_sync_i),
    .alarm_status_i(alarm_status_i), .conv_i_data_i(conv_i_data_i),
    .conv_q_data_i(conv_q_data_i), .i_path_dc_correction_o(i_cor),
    .q_path_dc_correction_o(q_cor), .offset_load_o(offset_load_o),
    .fifo_rdptr_load_o(rdptr), .fifo_rdptr_load_en_o(rdptr_en), .alarm_o(alarm_o),
    .alarm_active_o(alarm_active_o), .ptr_one_apart_flag_o(one_ap),
    .ptr_two_apart_flag_o(two_ap), .conv_i_out_o(conv_i_out_o), .conv_q_out_o(conv_q_out_o));
  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // inputs move 1 ns after the edge so the dut never races the bench
  task automatic tick;
    @(posedge core_clk_i) #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    tick;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick;
    reg_wr_i = 1'b0;
  endtask
  // read latency is one cycle, so no wait loop is needed
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    tick;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    tick;
    reg_rd_i = 1'b0;
    chk({15'h0, reg_rvalid_o}, 16'h0001);
    chk(reg_rdata_o & m, e);
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    rd(5'h07, 16'hffff, 16'hffff);
    rd(5'h09, 16'h8000, 16'hffff);
    rd(5'h08, 16'h0000, 16'hffff);
    wr(5'h0a, 16'hffff);
    rd(5'h0a, 16'h0000, 16'hffff);
  endtask
  task automatic t_temp;
    temp_sensor_i = 8'he7;
    // slow serial read: sensor word stays settled for one full serial period
    repeat (dar_pkg::DAR_TEMP_SCLK_CYCLES) tick;
    wr(5'h06, 16'h1234);
    rd(5'h06, 16'he700, 16'hffff);
  endtask
  task automatic t_mask;
    alarm_status_i = 16'hffff;
    wr(5'h07, 16'h0000);
    tick;
    chk(alarm_active_o, 16'hbfbc);
    chk({15'h0, alarm_o}, 16'h0001);
    wr(5'h07, 16'h2800);
    tick;
    chk(alarm_active_o, 16'h97bc);
    rd(5'h07, 16'h2800, 16'hbfbc);
    wr(5'h07, 16'h4043);
    rd(5'h07, 16'h0000, 16'hffff);
    alarm_status_i = 16'h0000;
  endtask
  task automatic t_offset;
    wr(5'h09, 16'h7abc);
    tick;
    chk({3'h0, q_cor}, 16'h0000);
    rd(5'h09, 16'h7abc, 16'hffff);
    fifo_sync_i = 1'b1;
    tick;
    fifo_sync_i = 1'b0;
    chk({12'h0, rdptr_en, rdptr}, 16'h000b);
    tick;
    chk({15'h0, rdptr_en}, 16'h0000);
    wr(5'h08, 16'hf234);
    chk({15'h0, offset_load_o}, 16'h0000);
    rd(5'h08, 16'h1234, 16'hffff);
    auto_sync_en_i = 1'b1;
    wr(5'h08, 16'h0555);
    chk({15'h0, offset_load_o}, 16'h0001);
    chk({3'h0, i_cor}, 16'h0555);
    chk({3'h0, q_cor}, 16'h1abc);
    auto_sync_en_i = 1'b0;
    tick;
    chk({15'h0, offset_load_o}, 16'h0000);
  endtask
  task automatic t_force;
    alarm_status_i = 16'h0100;
    tick;
    chk(conv_i_out_o, 16'h8000);
    chk(conv_q_out_o, 16'h8000);
    alarm_status_i = 16'h0800;
    tick;
    chk(conv_i_out_o, 16'h1234);
    chk(conv_q_out_o, 16'h4321);
    chk({14'h0, one_ap, two_ap}, 16'h0001);
    alarm_status_i = 16'h1000;
    #1;
    chk({14'h0, one_ap, two_ap}, 16'h0002);
    // collision bit alone clears both distance flags and forces the q converter output
    alarm_status_i = 16'h2000;
    tick;
    chk({14'h0, one_ap, two_ap}, 16'h0000);
    chk(conv_q_out_o, 16'h8000);
    alarm_status_i = 16'h0000;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, auto_sync_en_i, fifo_sync_i} = '0;
    {reg_addr_i, reg_wdata_i, temp_sensor_i, alarm_status_i} = '0;
    conv_i_data_i = 16'h1234;
    conv_q_data_i = 16'h4321;
    {failures, n_tests} = '0;
    repeat (2) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    t_reset;
    t_temp;
    t_mask;
    t_offset;
    t_force;
    close_out;
  end
endmodule
